//--- hdl/sorc_regs.vh
`ifndef SORC_REGS_VH
`define SORC_REGS_VH

// Register offsets (word index on the plain register port).
`define SORC_ADDR_CTRL      4'h0
`define SORC_ADDR_GPIO_CFG  4'h1
`define SORC_ADDR_DELAY     4'h2
`define SORC_ADDR_STATUS    4'h3
`define SORC_ADDR_IRQ_STAT  4'h4
`define SORC_ADDR_IRQ_MASK  4'h5
`define SORC_ADDR_FIELDSET  4'h6

// Control register fields.
`define SORC_CTRL_MODE_LSB  0
`define SORC_CTRL_MODE_MSB  1
`define SORC_CTRL_FBK_EN    2
`define SORC_CTRL_REMOTE    3
`define SORC_CTRL_RST       8'h00

// Restart modes.
`define SORC_MODE_NONE      2'h0
`define SORC_MODE_DELAY     2'h1
`define SORC_MODE_INTLK     2'h2

// Per connection config: [1:0] dir, [3:2] input function, [8:4] output sources.
`define SORC_DIR_OFF        2'h0
`define SORC_DIR_IN         2'h1
`define SORC_DIR_OUT        2'h2
`define SORC_IFN_STANDBY    2'h0
`define SORC_IFN_FBK        2'h1
`define SORC_IFN_RESET      2'h2
`define SORC_GPIO_CFG_RST   9'h000

// Output source select bits.
`define SORC_OSRC_DEVERR    0
`define SORC_OSRC_CONTERR   1
`define SORC_OSRC_CONTWARN  2
`define SORC_OSRC_WARN2     3
`define SORC_OSRC_RSTREQ    4

// Restart delay in seconds, and the 1 s tick.
`define SORC_DELAY_MIN_S    6'h02
`define SORC_DELAY_MAX_S    6'h3C
`define SORC_TICK_NS        1000000000
`define SORC_CLK_NS         10
`define SORC_TICK_CYCLES    (`SORC_TICK_NS / `SORC_CLK_NS)

// Field sets per variant.
`define SORC_FSETS_STD      5'h01
`define SORC_FSETS_REMOTE   5'h10

// Interrupt bits.
`define SORC_IRQ_OFF        0
`define SORC_IRQ_ON         1
`define SORC_IRQ_RSTREQ     2
`define SORC_IRQ_FBKFAIL    3

// Contactor feedback settle time after outputs turn on/off.
`define SORC_FBK_SETTLE     8'h64

`endif

//--- hdl/sorc_sync.v
`timescale 1ns/1ps
`default_nettype none

module sorc_sync (
    input  wire mclk,
    input  wire sys_rst,
    input  wire din,
    output reg  dout
);
    reg meta_r;

    always @(posedge mclk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // sorc_sync

`default_nettype wire

//--- hdl/sorc_tick.v
`timescale 1ns/1ps
`default_nettype none

// One-cycle pulse every TICK_CYCLES clocks; restarted by clr.
module sorc_tick #(
    parameter integer TICK_CYCLES = 100000000
) (
    input  wire mclk,
    input  wire sys_rst,
    input  wire clr,
    output reg  tick
);
    reg [26:0] cnt_r;

    always @(posedge mclk) begin
        if (sys_rst || clr) begin
            cnt_r <= 27'h0000000;
            tick  <= 1'b0;
        end else if (cnt_r == TICK_CYCLES[26:0] - 27'h0000001) begin
            cnt_r <= 27'h0000000;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 27'h0000001;
            tick  <= 1'b0;
        end
    end
endmodule // sorc_tick

`default_nettype wire

//--- hdl/sorc_restart.v
// Behaviour
// - No interlock: outputs follow field clear at once.
// - Restart delay selectable from 2 to 60 s.
// - Delay mode: ON after field clear whole delay.
// - Interlock: stay OFF after interruption clears.
// - Interlock: ON only after reset switch actuation.
// - Reset with field clear switches outputs ON.
// - Successful reset lights status indicator green.
// - Interlock: request reset after interruption then clear.
// - Two universal connections, default off, in/out.
// - Input connection carries exactly one function.
// - Output connection ORs its selected sources.
// - Interlock needs one connection as reset input.
// - Standby holds outputs OFF, laser off.
// - One field set standalone, sixteen remote.
// - Contactor fault: lock-out or OFF with error.
`timescale 1ns/1ps
`default_nettype none
`include "sorc_regs.vh"

module sorc_restart #(
    parameter integer TICK_CYCLES = `SORC_TICK_CYCLES
) (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        field_occupied,
    input  wire        dev_error,
    input  wire        cont_error,
    input  wire        cont_warning,
    input  wire        warn_field2,
    input  wire [1:0]  gpio_in,
    output reg  [1:0]  gpio_out,
    output reg  [1:0]  gpio_oe,
    output reg         safety_switch_output,
    output reg         laser_on,
    output reg         led_green,
    output reg         led_red,
    output reg         irq
);
    localparam [2:0] ST_OFF     = 3'h0;
    localparam [2:0] ST_DELAY   = 3'h1;
    localparam [2:0] ST_WAITRST = 3'h2;
    localparam [2:0] ST_ON      = 3'h3;
    localparam [2:0] ST_LOCK    = 3'h4;

    reg  [7:0] ctrl_r;
    reg  [8:0] gcfg0_r;
    reg  [8:0] gcfg1_r;
    reg  [5:0] delay_r;
    reg  [3:0] irq_stat_r;
    reg  [3:0] irq_mask_r;
    reg  [4:0] fset_r;
    reg  [2:0] st_r;
    reg  [2:0] st_nxt;
    reg  [5:0] secs_r;
    reg        rst_prev_r;
    reg        fbk_err_r;
    reg  [7:0] fbk_cnt_r;
    reg        green_r;

    wire       occ_s;
    wire [1:0] gin_s;
    wire       tick;

    sorc_sync u_sync_occ (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     (field_occupied),
        .dout    (occ_s)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_in
            sorc_sync u_sync (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .din     (gpio_in[g]),
                .dout    (gin_s[g])
            );
        end
    endgenerate

    wire [1:0] mode   = ctrl_r[`SORC_CTRL_MODE_MSB:`SORC_CTRL_MODE_LSB];
    wire       in0    = (gcfg0_r[1:0] == `SORC_DIR_IN);
    wire       in1    = (gcfg1_r[1:0] == `SORC_DIR_IN);
    wire       out0   = (gcfg0_r[1:0] == `SORC_DIR_OUT);
    wire       out1   = (gcfg1_r[1:0] == `SORC_DIR_OUT);

    // Each input connection drives exactly one selected function.
    wire sb_act  = (in0 && gcfg0_r[3:2] == `SORC_IFN_STANDBY && gin_s[0]) ||
                   (in1 && gcfg1_r[3:2] == `SORC_IFN_STANDBY && gin_s[1]);
    wire fbk_cfg = (in0 && gcfg0_r[3:2] == `SORC_IFN_FBK) ||
                   (in1 && gcfg1_r[3:2] == `SORC_IFN_FBK);
    wire fbk_in  = (in0 && gcfg0_r[3:2] == `SORC_IFN_FBK && gin_s[0]) ||
                   (in1 && gcfg1_r[3:2] == `SORC_IFN_FBK && gin_s[1]);
    wire rst_cfg = (in0 && gcfg0_r[3:2] == `SORC_IFN_RESET) ||
                   (in1 && gcfg1_r[3:2] == `SORC_IFN_RESET);
    wire rst_lvl = (in0 && gcfg0_r[3:2] == `SORC_IFN_RESET && gin_s[0]) ||
                   (in1 && gcfg1_r[3:2] == `SORC_IFN_RESET && gin_s[1]);
    // A reset is the rising edge of the switch input, so a stuck switch cannot rearm.
    wire rst_evt = rst_lvl && !rst_prev_r;

    // Interlock only takes effect with a reset input; otherwise it runs as plain restart.
    wire intlk   = (mode == `SORC_MODE_INTLK) && rst_cfg;
    wire dly_md  = (mode == `SORC_MODE_DELAY);
    wire [5:0] dly_eff = (delay_r < `SORC_DELAY_MIN_S) ? `SORC_DELAY_MIN_S :
                         (delay_r > `SORC_DELAY_MAX_S) ? `SORC_DELAY_MAX_S : delay_r;
    wire fbk_on  = ctrl_r[`SORC_CTRL_FBK_EN] && fbk_cfg;
    // Contactor feedback high means contacts released; it must be the inverse of the outputs after settling.
    wire fbk_bad = fbk_on && (fbk_cnt_r == `SORC_FBK_SETTLE) &&
                   (fbk_in == safety_switch_output);
    wire rst_req = (st_r == ST_WAITRST);

    sorc_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (st_r != ST_DELAY),
        .tick    (tick)
    );

    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF: begin
                if (!occ_s && !sb_act) begin
                    if (intlk)
                        st_nxt = ST_WAITRST;
                    else if (dly_md)
                        st_nxt = ST_DELAY;
                    else
                        st_nxt = ST_ON;
                end
            end
            ST_DELAY: begin
                if (occ_s || sb_act)
                    st_nxt = ST_OFF;
                else if (tick && secs_r + 6'h01 >= dly_eff)
                    st_nxt = ST_ON;
            end
            ST_WAITRST: begin
                if (occ_s || sb_act)
                    st_nxt = ST_OFF;
                else if (rst_evt)
                    st_nxt = ST_ON;
            end
            ST_ON: begin
                if (occ_s || sb_act)
                    st_nxt = ST_OFF;
            end
            ST_LOCK: st_nxt = ST_LOCK;
            default: st_nxt = ST_OFF;
        endcase
        if (fbk_bad && st_r != ST_LOCK)
            st_nxt = intlk ? ST_OFF : ST_LOCK;
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            st_r       <= ST_OFF;
            secs_r     <= 6'h00;
            rst_prev_r <= 1'b0;
            fbk_err_r  <= 1'b0;
            fbk_cnt_r  <= 8'h00;
            green_r    <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            rst_prev_r <= rst_lvl;
            if (st_r != ST_DELAY)
                secs_r <= 6'h00;
            else if (tick)
                secs_r <= secs_r + 6'h01;
            if (st_nxt != st_r && (st_nxt == ST_ON || st_r == ST_ON))
                fbk_cnt_r <= 8'h00;
            else if (fbk_cnt_r != `SORC_FBK_SETTLE)
                fbk_cnt_r <= fbk_cnt_r + 8'h01;
            if (fbk_bad)
                fbk_err_r <= 1'b1;
            else if (st_r == ST_WAITRST && rst_evt)
                fbk_err_r <= 1'b0;
            if (st_r == ST_WAITRST && st_nxt == ST_ON)
                green_r <= 1'b1;
            else if (st_nxt != ST_ON)
                green_r <= 1'b0;
        end
    end

    // Outputs and general-purpose connections.
    wire [4:0] srcs = {rst_req, warn_field2, cont_warning, cont_error, dev_error || fbk_err_r};
    always @(posedge mclk) begin
        if (sys_rst) begin
            safety_switch_output <= 1'b0;
            laser_on             <= 1'b0;
            led_green            <= 1'b0;
            led_red              <= 1'b1;
            gpio_out             <= 2'h0;
            gpio_oe              <= 2'h0;
            irq                  <= 1'b0;
        end else begin
            safety_switch_output <= (st_nxt == ST_ON);
            laser_on             <= !sb_act;
            led_green            <= (st_nxt == ST_ON) && (green_r || !intlk);
            led_red              <= (st_nxt != ST_ON);
            gpio_oe              <= {out1, out0};
            gpio_out[0]          <= out0 && |(gcfg0_r[8:4] & srcs);
            gpio_out[1]          <= out1 && |(gcfg1_r[8:4] & srcs);
            irq                  <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Register port; sticky bits: hardware set wins over write-one-to-clear.
    wire [3:0] ev = {fbk_bad, (st_r != ST_WAITRST) && (st_nxt == ST_WAITRST),
                     (st_r != ST_ON) && (st_nxt == ST_ON), (st_r == ST_ON) && (st_nxt != ST_ON)};
    always @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r     <= `SORC_CTRL_RST;
            gcfg0_r    <= `SORC_GPIO_CFG_RST;
            gcfg1_r    <= `SORC_GPIO_CFG_RST;
            delay_r    <= `SORC_DELAY_MIN_S;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            fset_r     <= 5'h00;
            reg_rdata  <= 32'h00000000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `SORC_ADDR_CTRL: ctrl_r <= reg_wdata[7:0];
                    `SORC_ADDR_GPIO_CFG: begin
                        gcfg0_r <= reg_wdata[8:0];
                        gcfg1_r <= reg_wdata[24:16];
                    end
                    `SORC_ADDR_DELAY: delay_r <= reg_wdata[5:0];
                    `SORC_ADDR_IRQ_MASK: irq_mask_r <= reg_wdata[3:0];
                    `SORC_ADDR_FIELDSET: begin
                        // Only the remote variant has more than one field set.
                        if (reg_wdata[4:0] < (ctrl_r[`SORC_CTRL_REMOTE] ? `SORC_FSETS_REMOTE
                                                                        : `SORC_FSETS_STD))
                            fset_r <= reg_wdata[4:0];
                    end
                    default: ;
                endcase
            end
            if (reg_wr && reg_addr == `SORC_ADDR_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~reg_wdata[3:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `SORC_ADDR_CTRL:     reg_rdata <= {24'h000000, ctrl_r};
                    `SORC_ADDR_GPIO_CFG: reg_rdata <= {7'h00, gcfg1_r, 7'h00, gcfg0_r};
                    `SORC_ADDR_DELAY:    reg_rdata <= {26'h0000000, dly_eff};
                    `SORC_ADDR_STATUS:   reg_rdata <= {22'h000000, fbk_err_r, rst_req, sb_act,
                                                       occ_s, safety_switch_output, intlk, 1'b0, st_r};
                    `SORC_ADDR_IRQ_STAT: reg_rdata <= {28'h0000000, irq_stat_r};
                    `SORC_ADDR_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask_r};
                    `SORC_ADDR_FIELDSET: reg_rdata <= {27'h0000000, fset_r};
                    default:             reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // sorc_restart

`default_nettype wire

//--- testbench/sorc_restart_props.sv
`timescale 1ns/1ps
`default_nettype none
module sorc_restart_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_rdata,
    input wire logic        field_occupied,
    input wire logic [1:0]  gpio_oe,
    input wire logic        safety_switch_output,
    input wire logic        laser_on,
    input wire logic        led_green,
    input wire logic        led_red
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_OFF_FAST:
        assert property ($rose(field_occupied) |-> ##[1:5] !safety_switch_output) else $error("slow off");
    AST_HOLD_OFF:
        assert property (field_occupied [*6] |-> !safety_switch_output) else $error("on while occupied");
    AST_STBY_OFF:
        assert property (!laser_on |-> !safety_switch_output) else $error("on in standby");
    AST_GREEN_ON:
        assert property (led_green |-> safety_switch_output) else $error("green while off");
    AST_RED_OFF:
        assert property (led_red |-> !safety_switch_output) else $error("red while on");
    AST_ON_CLEAR:
        assert property ($rose(safety_switch_output) |-> !$past(field_occupied, 2)) else $error("on while occupied");
    AST_OE_CFG:
        assert property ($changed(gpio_oe) |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("oe moved alone");
    AST_RDATA_IDLE:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
    COV_ON: cover property ($rose(safety_switch_output));
    COV_STBY: cover property ($fell(laser_on));
    COV_GREEN: cover property ($rose(led_green));
endmodule // sorc_restart_props
bind sorc_restart sorc_restart_props u_props (.mclk, .sys_rst, .reg_rd, .reg_wr, .reg_rdata, .field_occupied,
    .gpio_oe, .safety_switch_output, .laser_on, .led_green, .led_red);
`default_nettype wire

//--- testbench/sorc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sorc_partner (
    input  wire logic       mclk,
    input  wire logic       press,
    input  wire logic       stby,
    input  wire logic       start,
    input  wire logic       ssw,
    input  wire logic [1:0] gpio_out,
    input  wire logic [1:0] gpio_oe,
    output wire logic [1:0] gpio_in,
    output var  logic       machine_run
);
    logic [2:0] pulse_r = 3'h0;
    initial machine_run = 1'b0;
    // The switch is held for four cycles per press; the block takes any rising edge on it as a reset.
    always @(posedge mclk) begin
        if (press)
            pulse_r <= 3'h4;
        else if (pulse_r != 3'h0)
            pulse_r <= pulse_r - 3'h1;
    end
    assign gpio_in[0] = gpio_oe[0] ? gpio_out[0] : (pulse_r != 3'h0);
    assign gpio_in[1] = gpio_oe[1] ? gpio_out[1] : stby;
    always @(posedge mclk) begin
        if (!ssw)
            machine_run <= 1'b0;
        else if (start)
            machine_run <= 1'b1;
    end
endmodule // sorc_partner
`default_nettype wire

//--- testbench/sorc_restart_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sorc_restart_tb_top;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        field_occupied = 1'b0;
    logic [3:0]  src = 4'h0;
    logic        press = 1'b0;
    logic        stby = 1'b0;
    logic        start = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [1:0]  gpio_in, gpio_out, gpio_oe;
    logic        ssw, laser_on, led_green, led_red, irq, machine_run;
    logic [15:0] seed = 16'h02AA;
    int          failures = 0;
    int          checks = 0;
    int          cyc = 0;
    always #5 mclk = ~mclk;
    sorc_restart #(.TICK_CYCLES(10)) DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .field_occupied(field_occupied), .dev_error(src[0]), .cont_error(src[1]), .cont_warning(src[2]),
        .warn_field2(src[3]), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .safety_switch_output(ssw), .laser_on(laser_on), .led_green(led_green), .led_red(led_red), .irq(irq));
    sorc_partner u_partner (.mclk(mclk), .press(press), .stby(stby), .start(start), .ssw(ssw),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .machine_run(machine_run));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chb(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wt(input logic v);
        for (int n = 0; n < 60 && ssw !== v; n++) @(negedge mclk);
        chb("ssw", v, ssw);
    endtask
    task automatic occ_pulse;
        @(posedge mclk) field_occupied <= 1'b1;
        tick(6);
        wt(1'b0);
        @(posedge mclk) field_occupied <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            results();
        end
    end
    initial begin
        tick(5);
        sys_rst <= 1'b0;
        rd(4'h1); chk("gpio_cfg", 32'h0, rv);
        rd(4'h2); chk("delay", 32'h2, rv);
        rd(4'h7); chk("unmapped", 32'h0, rv);
        wt(1'b1);
        occ_pulse();
        wt(1'b1);
        wr(4'h2, 32'h3D); rd(4'h2); chk("delay", 32'h3C, rv);
        wr(4'h2, 32'h1); rd(4'h2); chk("delay", 32'h2, rv);
        wr(4'h0, 32'h1);
        occ_pulse();
        tick(12); chb("ssw", 1'b0, ssw);
        occ_pulse();
        tick(15); chb("ssw", 1'b0, ssw);
        wt(1'b1);
        // Connection 0 takes the reset switch, connection 1 reports that a reset is due.
        wr(4'h1, 32'h0102_0009);
        wr(4'h0, 32'h2);
        occ_pulse();
        tick(30); chb("ssw", 1'b0, ssw);
        chb("gpio_out1", 1'b1, gpio_out[1]);
        rd(4'h3); chb("reset_req", 1'b1, rv[8]);
        @(posedge mclk) start <= 1'b1;
        @(posedge mclk) start <= 1'b0;
        tick(1); chb("machine_run", 1'b0, machine_run);
        @(posedge mclk) press <= 1'b1;
        @(posedge mclk) press <= 1'b0;
        wt(1'b1);
        tick(2); chb("led_green", 1'b1, led_green);
        chb("gpio_out1", 1'b0, gpio_out[1]);
        @(posedge mclk) start <= 1'b1;
        @(posedge mclk) start <= 1'b0;
        tick(1); chb("machine_run", 1'b1, machine_run);
        wr(4'h1, 32'h0);
        occ_pulse();
        wt(1'b1);
        wr(4'h0, 32'h0);
        wr(4'h1, 32'h0001_0000);
        @(posedge mclk) stby <= 1'b1;
        tick(8); chb("ssw", 1'b0, ssw);
        chb("laser_on", 1'b0, laser_on);
        chb("led_red", 1'b1, led_red);
        @(posedge mclk) stby <= 1'b0;
        wt(1'b1);
        chb("laser_on", 1'b1, laser_on);
        wr(4'h1, 32'h00F2_0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            @(posedge mclk) src <= seed[3:0];
            tick(3); chb("gpio_out1", |seed[3:0], gpio_out[1]);
        end
        chk("gpio_oe", 32'h2, {30'h0, gpio_oe});
        wr(4'h6, 32'h5); rd(4'h6); chk("fieldset", 32'h0, rv);
        wr(4'h0, 32'h8); wr(4'h6, 32'hF); rd(4'h6); chk("fieldset", 32'hF, rv);
        wr(4'h6, 32'h10); rd(4'h6); chk("fieldset", 32'hF, rv);
        wr(4'h0, 32'h0); wr(4'h5, 32'h1); wr(4'h4, 32'hF);
        tick(2); chb("irq", 1'b0, irq);
        occ_pulse();
        tick(2); chb("irq", 1'b1, irq);
        wr(4'h4, 32'h1);
        tick(2); chb("irq", 1'b0, irq);
        // Contactor feedback on connection 0; a stuck released contact locks the block out.
        wr(4'h0, 32'h4);
        wr(4'h1, 32'h5);
        wt(1'b1);
        tick(110);
        @(posedge mclk) press <= 1'b1;
        @(posedge mclk) press <= 1'b0;
        tick(8); chb("ssw", 1'b0, ssw);
        chb("led_red", 1'b1, led_red);
        rd(4'h3); chk("status", 32'h204, rv);
        sys_rst <= 1'b1;
        tick(5);
        sys_rst <= 1'b0;
        wt(1'b1);
        chb("led_red", 1'b0, led_red);
        results();
    end
endmodule // sorc_restart_tb_top
`default_nettype wire
